// >>> dmagc_top.sv
`timescale 1ns/1ps
`include "dmagc_regs.svh"
// Functional notes
// - both global registers are 16-bit read/write in dsp i/o space
// - unused upper bits read zero: control 15..4, index mode 15..1
// - control bit 3 resets to one; software always writes one
// - free bit clear: breakpoint suspends transfers; set: transfers continue
// - exclusive clear: host shares ram, reaches internal and external memory
// - exclusive set: channels needing dual or single access ram suspended
// - exclusive set: host limited to ram ports, external port blocked
// - host port never gets the peripheral port
// - priority bit: zero low, one high in the service chain
// - in exclusive mode priority has no effect at the ram ports
// - index mode clear: source indexes serve source and destination
// - index mode set: destination uses its own index registers
// - sharing host gets service cycles like a channel
module dmagc_top (
    input  wire logic                      i_core_clk,
    input  wire logic                      i_nrst,
    input  wire dmagc_pkg::dmagc_io_req_t  i_io_req,
    input  wire logic                      i_emu_break,
    output logic [`DMAGC_DATA_W-1:0]       o_io_rdata,
    output logic                           o_io_rvalid,
    output logic                           o_xfer_suspend,
    output logic                           o_dst_idx_separate,
    output dmagc_pkg::dmagc_gate_t         o_gate
);

    logic [`DMAGC_CTRL_W-1:0]  ctrl_ff;
    logic [`DMAGC_CTRL_W-1:0]  nxt_ctrl;
    logic [`DMAGC_IDX_W-1:0]   idx_ff;
    logic [`DMAGC_IDX_W-1:0]   nxt_idx;
    logic [`DMAGC_DATA_W-1:0]  rdata_ff;
    logic [`DMAGC_DATA_W-1:0]  nxt_rdata;
    logic                      rvalid_ff;
    logic                      nxt_rvalid;
    logic                      brk_meta_ff;
    logic                      brk_sync_ff;
    logic                      nxt_brk_meta;
    logic                      nxt_brk_sync;
    logic                      susp_ff;
    logic                      nxt_susp;
    dmagc_pkg::dmagc_sel_t     sel;

    function automatic dmagc_pkg::dmagc_sel_t decode(
        input logic [`DMAGC_ADDR_W-1:0] a
    );
        if (a == `DMAGC_CTRL_ADDR) begin
            decode = dmagc_pkg::DMAGC_SEL_CTRL;
        end else if (a == `DMAGC_IDXMD_ADDR) begin
            decode = dmagc_pkg::DMAGC_SEL_IDX;
        end else begin
            decode = dmagc_pkg::DMAGC_SEL_NONE;
        end
    endfunction : decode

    assign sel = decode(i_io_req.addr);

    // register writes and read data
    always_comb begin
        nxt_ctrl   = ctrl_ff;
        nxt_idx    = idx_ff;
        nxt_rdata  = rdata_ff;
        nxt_rvalid = i_io_req.rd;
        if (i_io_req.wr) begin
            case (sel)
                dmagc_pkg::DMAGC_SEL_CTRL: begin
                    nxt_ctrl = i_io_req.wdata[`DMAGC_CTRL_W-1:0];
                end
                dmagc_pkg::DMAGC_SEL_IDX: begin
                    nxt_idx = i_io_req.wdata[`DMAGC_IDX_W-1:0];
                end
                default: begin
                end
            endcase
        end
        if (i_io_req.rd) begin
            nxt_rdata = `DMAGC_ZERO16;
            case (sel)
                dmagc_pkg::DMAGC_SEL_CTRL: begin
                    nxt_rdata[`DMAGC_CTRL_W-1:0] = ctrl_ff;
                end
                dmagc_pkg::DMAGC_SEL_IDX: begin
                    nxt_rdata[`DMAGC_IDX_W-1:0] = idx_ff;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl_ff   <= `DMAGC_CTRL_RST;
            idx_ff    <= `DMAGC_IDX_RST;
            rdata_ff  <= `DMAGC_ZERO16;
            rvalid_ff <= 1'b0;
        end else begin
            ctrl_ff   <= nxt_ctrl;
            idx_ff    <= nxt_idx;
            rdata_ff  <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    // breakpoint handling
    always_comb begin
        nxt_brk_meta = i_emu_break;
        nxt_brk_sync = brk_meta_ff;
        nxt_susp     = brk_sync_ff & ~ctrl_ff[`DMAGC_CTRL_FREE_BIT];
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            brk_meta_ff <= 1'b0;
            brk_sync_ff <= 1'b0;
            susp_ff     <= 1'b0;
        end else begin
            brk_meta_ff <= nxt_brk_meta;
            brk_sync_ff <= nxt_brk_sync;
            susp_ff     <= nxt_susp;
        end
    end

    dmagc_gate u_gate (
        .i_excl (ctrl_ff[`DMAGC_CTRL_EXCL_BIT]),
        .i_prio (ctrl_ff[`DMAGC_CTRL_PRIO_BIT]),
        .o_gate (o_gate)
    );

    assign o_io_rdata         = rdata_ff;
    assign o_io_rvalid        = rvalid_ff;
    assign o_xfer_suspend     = susp_ff;
    assign o_dst_idx_separate = idx_ff[`DMAGC_IDX_MODE_BIT];

    // checks
    property p_rd_ctrl;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (i_io_req.rd && sel == dmagc_pkg::DMAGC_SEL_CTRL && !i_io_req.wr)
            |=> (o_io_rvalid && o_io_rdata[`DMAGC_CTRL_W-1:0] == ctrl_ff);
    endproperty
    ctrl_read_a: assert property (p_rd_ctrl)
        else $error("control read data mismatch");
    idx_read_a: assert property (@(posedge i_core_clk)
        disable iff (!i_nrst)
        (i_io_req.rd && sel == dmagc_pkg::DMAGC_SEL_IDX && !i_io_req.wr)
        |=> o_io_rdata[`DMAGC_IDX_W-1:0] == idx_ff)
        else $error("index mode read data mismatch");
    rvalid_pulse_a: assert property (@(posedge i_core_clk)
        disable iff (!i_nrst)
        o_io_rvalid == $past(i_io_req.rd))
        else $error("read valid not one cycle after read");
    ctrl_hold_a: assert property (@(posedge i_core_clk)
        disable iff (!i_nrst)
        !(i_io_req.wr && sel == dmagc_pkg::DMAGC_SEL_CTRL)
        |=> $stable(ctrl_ff))
        else $error("control register changed without a write");
    upper_zero_a: assert property (@(posedge i_core_clk)
        disable iff (!i_nrst)
        o_io_rvalid |-> o_io_rdata[`DMAGC_DATA_W-1:`DMAGC_CTRL_W] == '0)
        else $error("upper read bits not zero");
    idx_upper_a: assert property (@(posedge i_core_clk)
        disable iff (!i_nrst)
        (i_io_req.rd && sel == dmagc_pkg::DMAGC_SEL_IDX)
        |=> o_io_rdata[`DMAGC_DATA_W-1:`DMAGC_IDX_W] == '0)
        else $error("index mode upper bits not zero");
    none_read_a: assert property (@(posedge i_core_clk)
        disable iff (!i_nrst)
        (i_io_req.rd && sel == dmagc_pkg::DMAGC_SEL_NONE)
        |=> o_io_rdata == `DMAGC_ZERO16)
        else $error("unmapped read not zero");
    bit3_write_a: assert property (@(posedge i_core_clk)
        disable iff (!i_nrst)
        (i_io_req.wr && sel == dmagc_pkg::DMAGC_SEL_CTRL)
        |=> ctrl_ff[`DMAGC_CTRL_RSV3_BIT]
            == $past(i_io_req.wdata[`DMAGC_CTRL_RSV3_BIT]))
        else $error("bit 3 not stored");
    brk_susp_a: assert property (@(posedge i_core_clk)
        disable iff (!i_nrst)
        (i_emu_break && !ctrl_ff[`DMAGC_CTRL_FREE_BIT])[*4]
        |-> o_xfer_suspend)
        else $error("breakpoint did not suspend");
    free_run_a: assert property (@(posedge i_core_clk)
        disable iff (!i_nrst)
        ctrl_ff[`DMAGC_CTRL_FREE_BIT] |=> !o_xfer_suspend)
        else $error("free mode suspended");
    shared_gate_a: assert property (@(posedge i_core_clk)
        disable iff (!i_nrst)
        !ctrl_ff[`DMAGC_CTRL_EXCL_BIT] |-> (o_gate.host_ext_ok
        && !o_gate.dual_access_ram_chan_hold
        && !o_gate.single_access_ram_chan_hold))
        else $error("shared gating wrong");
    excl_gate_a: assert property (@(posedge i_core_clk)
        disable iff (!i_nrst)
        ctrl_ff[`DMAGC_CTRL_EXCL_BIT]
        |-> (o_gate.dual_access_ram_chan_hold
        && o_gate.single_access_ram_chan_hold))
        else $error("exclusive gating wrong");
    excl_port_a: assert property (@(posedge i_core_clk)
        disable iff (!i_nrst)
        ctrl_ff[`DMAGC_CTRL_EXCL_BIT]
        |-> (!o_gate.host_ext_ok && o_gate.host_dual_access_ram_ok
        && o_gate.host_single_access_ram_ok))
        else $error("exclusive host port reach wrong");
    periph_block_a: assert property (@(posedge i_core_clk)
        disable iff (!i_nrst)
        !o_gate.host_periph_ok)
        else $error("host reached peripheral port");
    prio_level_a: assert property (@(posedge i_core_clk)
        disable iff (!i_nrst)
        !ctrl_ff[`DMAGC_CTRL_EXCL_BIT]
        |-> o_gate.host_high_prio == ctrl_ff[`DMAGC_CTRL_PRIO_BIT])
        else $error("host priority level wrong");
    excl_prio_a: assert property (@(posedge i_core_clk)
        disable iff (!i_nrst)
        ctrl_ff[`DMAGC_CTRL_EXCL_BIT] |-> !o_gate.host_high_prio)
        else $error("priority active in exclusive mode");
    idx_hold_a: assert property (@(posedge i_core_clk)
        disable iff (!i_nrst)
        !(i_io_req.wr && sel == dmagc_pkg::DMAGC_SEL_IDX)
        |=> $stable(o_dst_idx_separate))
        else $error("index mode changed without a write");
    idx_mode_a: assert property (@(posedge i_core_clk)
        disable iff (!i_nrst)
        (i_io_req.wr && sel == dmagc_pkg::DMAGC_SEL_IDX)
        |=> o_dst_idx_separate == $past(i_io_req.wdata[`DMAGC_IDX_MODE_BIT]))
        else $error("index mode not applied");

    excl_c: cover property (@(posedge i_core_clk)
        $rose(ctrl_ff[`DMAGC_CTRL_EXCL_BIT]));
    brk_c: cover property (@(posedge i_core_clk)
        $rose(o_xfer_suspend));
    idx_c: cover property (@(posedge i_core_clk)
        $rose(o_dst_idx_separate));
    none_c: cover property (@(posedge i_core_clk)
        i_io_req.rd && sel == dmagc_pkg::DMAGC_SEL_NONE);
    free_brk_c: cover property (@(posedge i_core_clk)
        brk_sync_ff && ctrl_ff[`DMAGC_CTRL_FREE_BIT]);

endmodule : dmagc_top

// >>> dmagc_regs.svh
`ifndef DMAGC_REGS_SVH
`define DMAGC_REGS_SVH

// i/o addresses of the two global registers (placement is a local choice)
`define DMAGC_ADDR_W            16
`define DMAGC_CTRL_ADDR         16'h0e00
`define DMAGC_IDXMD_ADDR        16'h0e02

// control register fields
`define DMAGC_CTRL_PRIO_BIT     0
`define DMAGC_CTRL_EXCL_BIT     1
`define DMAGC_CTRL_FREE_BIT     2
`define DMAGC_CTRL_RSV3_BIT     3
`define DMAGC_CTRL_W            4
`define DMAGC_CTRL_RST          4'h8

// index-mode register fields
`define DMAGC_IDX_MODE_BIT      0
`define DMAGC_IDX_W             1
`define DMAGC_IDX_RST           1'h0

`define DMAGC_DATA_W            16
`define DMAGC_ZERO16            16'h0000

`endif

// >>> dmagc_pkg.sv
`include "dmagc_regs.svh"

package dmagc_pkg;

    // i/o space access from the dsp core
    typedef struct packed {
        logic                       rd;
        logic                       wr;
        logic [`DMAGC_ADDR_W-1:0]   addr;
        logic [`DMAGC_DATA_W-1:0]   wdata;
    } dmagc_io_req_t;

    // per-port gating toward the channel scheduler
    typedef struct packed {
        logic   dual_access_ram_chan_hold;
        logic   single_access_ram_chan_hold;
        logic   host_dual_access_ram_ok;
        logic   host_single_access_ram_ok;
        logic   host_ext_ok;
        logic   host_periph_ok;
        logic   host_high_prio;
    } dmagc_gate_t;

    typedef enum logic [1:0] {
        DMAGC_SEL_NONE,
        DMAGC_SEL_CTRL,
        DMAGC_SEL_IDX
    } dmagc_sel_t;

endpackage : dmagc_pkg

// >>> dmagc_gate.sv
`timescale 1ns/1ps
`include "dmagc_regs.svh"

module dmagc_gate (
    input  wire logic                      i_excl,
    input  wire logic                      i_prio,
    output dmagc_pkg::dmagc_gate_t         o_gate
);

    always_comb begin
        // channels held off the internal ram ports while host owns them
        o_gate.dual_access_ram_chan_hold   = i_excl;
        o_gate.single_access_ram_chan_hold = i_excl;
        o_gate.host_dual_access_ram_ok     = 1'b1;
        o_gate.host_single_access_ram_ok   = 1'b1;
        // shared mode reaches external too; exclusive blocks it
        o_gate.host_ext_ok                 = ~i_excl;
        o_gate.host_periph_ok              = 1'b0;
        // priority only matters where channels still compete
        o_gate.host_high_prio              = i_prio & ~i_excl;
    end

endmodule : dmagc_gate

// >>> dmagc_core_model.sv
`timescale 1ns/1ps
`include "dmagc_regs.svh"
module dmagc_core_model (
    input  wire logic                     i_core_clk,
    input  wire logic [15:0]              i_io_rdata,
    input  wire logic                     i_io_rvalid,
    output dmagc_pkg::dmagc_io_req_t      o_io_req
);
    initial o_io_req = '0;
    task write(input logic [15:0] a, input logic [15:0] v);
        logic [15:0] d;
        d = (a == `DMAGC_CTRL_ADDR) ? (v | 16'h0008) : v;
        @(posedge i_core_clk);
        o_io_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge i_core_clk);
        o_io_req <= '0;
    endtask : write
    task read(input logic [15:0] a, output logic [15:0] d, output logic ok);
        ok = 1'b0;
        d = 16'h0000;
        @(posedge i_core_clk);
        o_io_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h5a5a};
        @(posedge i_core_clk);
        o_io_req <= '0;
        for (int n = 0; n < 3 && !ok; n++) begin
            #1;
            if (i_io_rvalid === 1'b1) begin
                ok = 1'b1;
                d = i_io_rdata;
            end else @(posedge i_core_clk);
        end
    endtask : read
endmodule : dmagc_core_model

// >>> dma_global_control_bench.sv
`timescale 1ns/1ps
`include "dmagc_regs.svh"
module dma_global_control_bench;
    logic                      clk;
    logic                      nrst;
    logic                      brk;
    logic                      rvalid;
    logic                      susp;
    logic                      dsep;
    logic                      ok;
    logic [15:0]               rdata;
    logic [15:0]               d;
    dmagc_pkg::dmagc_io_req_t  req;
    dmagc_pkg::dmagc_gate_t    gate;
    int                        failures;
    int                        checked;
    typedef struct packed {
        logic [15:0] w;
        logic [15:0] r;
        logic [6:0]  g;
    } dmagc_row_t;
    // hold d, hold s, ok d, ok s, ok ext, ok periph, high prio
    dmagc_row_t rows [5] = '{
        '{16'hfff8, 16'h0008, 7'h1c}, '{16'h0009, 16'h0009, 7'h1d},
        '{16'h000a, 16'h000a, 7'h78}, '{16'h000b, 16'h000b, 7'h78},
        '{16'h000c, 16'h000c, 7'h1c}};
    dmagc_top DUT (.i_core_clk(clk), .i_nrst(nrst), .i_io_req(req),
        .i_emu_break(brk), .o_io_rdata(rdata), .o_io_rvalid(rvalid),
        .o_xfer_suspend(susp), .o_dst_idx_separate(dsep), .o_gate(gate));
    dmagc_core_model CORE (.i_core_clk(clk), .i_io_rdata(rdata),
        .i_io_rvalid(rvalid), .o_io_req(req));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task end_of_test;
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_of_test
    task rdchk(input logic [15:0] a, input logic [15:0] exp);
        CORE.read(a, d, ok);
        if (!ok) begin
            failures++;
            end_of_test();
        end else begin
            chk(d, exp);
        end
    endtask : rdchk
    task brkchk(input logic v, input logic exp);
        @(posedge clk);
        brk <= v;
        // two sync stages plus the suspend flop
        repeat (3) @(posedge clk);
        #1 chk({15'h0, susp}, {15'h0, exp});
    endtask : brkchk
    initial begin
        nrst = 1'b0;
        brk = 1'b0;
        failures = 0;
        checked = 0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        #1 chk({9'h0, gate}, 16'h001c);
        rdchk(`DMAGC_CTRL_ADDR, 16'h0008);
        rdchk(`DMAGC_IDXMD_ADDR, 16'h0000);
        $display("reset test done");
        foreach (rows[i]) begin
            CORE.write(`DMAGC_CTRL_ADDR, rows[i].w);
            rdchk(`DMAGC_CTRL_ADDR, rows[i].r);
            chk({9'h0, gate}, {9'h0, rows[i].g});
        end
        $display("control table test done");
        CORE.write(`DMAGC_IDXMD_ADDR, 16'hffff);
        rdchk(`DMAGC_IDXMD_ADDR, 16'h0001);
        chk({15'h0, dsep}, 16'h0001);
        CORE.write(`DMAGC_IDXMD_ADDR, 16'hfffe);
        #1 chk({15'h0, dsep}, 16'h0000);
        CORE.write(16'h0e04, 16'h0001);
        #1 chk({15'h0, dsep}, 16'h0000);
        rdchk(16'h0e04, 16'h0000);
        $display("index mode test done");
        brkchk(1'b1, 1'b0);
        CORE.write(`DMAGC_CTRL_ADDR, 16'h0008);
        brkchk(1'b1, 1'b1);
        brkchk(1'b0, 1'b0);
        $display("breakpoint test done");
        CORE.write(`DMAGC_IDXMD_ADDR, 16'h0001);
        CORE.write(`DMAGC_CTRL_ADDR, 16'h000f);
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rdchk(`DMAGC_CTRL_ADDR, 16'h0008);
        chk({9'h0, gate}, 16'h001c);
        chk({15'h0, dsep}, 16'h0000);
        $display("mid-run reset test done");
        end_of_test();
    end
endmodule : dma_global_control_bench
